// [design/press_monitor_cfg.svh]
`ifndef PRESS_MONITOR_CFG_SVH
`define PRESS_MONITOR_CFG_SVH

// Logic cycle rate
`define CLK_HZ 25000000

// Restart pulse limits, in milliseconds
`define RESTART_MIN_SHORT_MS 100
`define RESTART_MIN_LONG_MS 350
`define RESTART_MAX_MS 30000

// Milliseconds to logic cycles; the rate divides evenly, so no rounding arises
`define MS_TO_CYC(ms) ((ms) * (`CLK_HZ / 1000))

// Register offsets (byte addresses)
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04

// Control register fields
`define CTRL_RUN_BIT 0
`define CTRL_RESTART_EN_BIT 1
`define CTRL_EARLY_EN_BIT 2
`define CTRL_ANYFLT_EN_BIT 3
`define CTRL_MIN_LONG_BIT 4
`define CTRL_WIDTH 5
`define CTRL_RESET 5'h0b

// Status register fields
`define STAT_TOP_BIT 0
`define STAT_UP_BIT 1
`define STAT_PERMIT_BIT 2
`define STAT_SEQ_BIT 3
`define STAT_OVER_BIT 4
`define STAT_PEND_BIT 5
`define STAT_ANY_BIT 6
`define STAT_PHASE_LSB 8

`endif

// [design/press_monitor_pkg.sv]
package press_monitor_pkg;

    // Press phase; Gray codes along top -> down -> up -> over -> top
    typedef enum logic [2:0] {
        ST_TOP = 3'h0,
        ST_DOWN = 3'h1,
        ST_UP = 3'h3,
        ST_OVER = 3'h2,
        ST_FAULT = 3'h6,
        ST_HALT = 3'h4
    } phase_t;

    typedef logic [7:0] reg_addr_t;
    typedef logic [31:0] reg_data_t;

endpackage

// [design/restart_pulse_check.sv]
// Qualifies a low-high-low pulse by the number of cycles it stayed high
module restart_pulse_check #(
    parameter int CNT_W = 30
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic level,
    input wire logic [CNT_W-1:0] min_cyc,
    input wire logic [CNT_W-1:0] max_cyc,
    output logic valid
);
    logic level_q;
    logic [CNT_W-1:0] cnt_q;
    logic valid_q;

    // Previous level for edge detection
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level;
        end
    end

    // High-time counter; saturates so an endless high never wraps into range
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (!level) begin
            cnt_q <= '0;
        end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Verdict on the falling edge; too short or too long gives nothing
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= level_q && !level && (cnt_q >= min_cyc) && (cnt_q <= max_cyc); // [RL17]
        end
    end

    assign valid = valid_q;

endmodule // restart_pulse_check

// [design/press_contact_sequence_monitor.sv]
// Operation
// RL1 - Leaving top centre when stopped is overrun
// RL2 - Start rise or high at top-zone end
// RL3 - Startup-zone rise raises upstroke zone
// RL4 - Top-centre rise or early fall clears upstroke
// RL5 - Early fall in downstroke holds top zone
// RL6 - Early fall in downstroke blocks upstroke zone
// RL7 - Permit low suspends monitoring, faults kept
// RL8 - Permit rise enters state from contacts
// RL9 - Permit out high when permitted, faultless
// RL10 - Faults latch until valid restart pulse
// RL11 - Top-centre rise or early fall sets top
// RL12 - Top-centre fall clears top zone
// RL13 - Fault forces both zone outputs low
// RL14 - Reset pending blocks permit until restart
// RL15 - Wrong contact order raises sequence fault
// RL16 - Any-fault output mirrors faults when enabled
// RL17 - Restart pulse between minimum and 30 s
// RL18 - Restart disabled: only run toggle clears
// RL19 - Switches must alternate in fixed order
// RL20 - Inputs sampled each cycle, edges by comparison
`include "press_monitor_cfg.svh"

module press_contact_sequence_monitor #(
    parameter int MIN_SHORT_CYC = `MS_TO_CYC(`RESTART_MIN_SHORT_MS),
    parameter int MIN_LONG_CYC = `MS_TO_CYC(`RESTART_MIN_LONG_MS),
    parameter int MAX_CYC = `MS_TO_CYC(`RESTART_MAX_MS),
    parameter int CNT_W = 30
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic top_centre_switch,
    input wire logic startup_zone_switch,
    input wire logic early_top_switch,
    input wire logic permit_in,
    input wire logic restart_in,
    input wire logic drive_start,
    input wire press_monitor_pkg::reg_addr_t reg_addr,
    input wire press_monitor_pkg::reg_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output press_monitor_pkg::reg_data_t reg_rdata,
    output logic top_zone,
    output logic upstroke_zone,
    output logic permit_out,
    output logic seq_fault,
    output logic overrun_fault,
    output logic reset_pending,
    output logic any_fault
);
    import press_monitor_pkg::*;

    // Settings the logic cannot serve
    if (MIN_SHORT_CYC < 1 || MIN_LONG_CYC < MIN_SHORT_CYC || MAX_CYC < MIN_LONG_CYC) begin : g_bad
        $error("restart pulse limits out of order");
    end
    if (MAX_CYC >= (2 ** CNT_W) - 1) begin : g_wide
        $error("restart counter too narrow");
    end

    localparam int NIN = 5;
    logic [NIN-1:0] pins;
    logic [NIN-1:0] sync1_q;
    logic [NIN-1:0] sync2_q;
    logic [NIN-1:0] prev_q;
    logic tdc_s, bdc_s, early_s, permit_s, restart_s;
    logic tdc_rise, tdc_fall, bdc_rise, bdc_fall, early_fall;
    logic start_p_q, start_rise;
    logic [`CTRL_WIDTH-1:0] ctrl_q;
    logic run_q, restart_en, early_en, anyflt_en;
    phase_t st_q, st_d;
    logic top_q, top_d, up_q, up_d;
    logic early_dn_q, early_dn_d, early_used_q, early_used_d;
    logic start_seen_q, start_seen_d;
    logic seq_evt, over_evt, early_f;
    logic seq_fault_q, seq_fault_d, over_fault_q, over_fault_d, fault_d;
    logic pend_q, permit_q, any_q;
    logic restart_valid, clear_ev;
    logic [CNT_W-1:0] min_cyc;
    reg_data_t rdata_q, status;

    assign pins = {restart_in, permit_in, early_top_switch, startup_zone_switch,
                   top_centre_switch};

    // Two-stage synchroniser, then one more stage kept only for edge detection
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q <= sync2_q; // [RL20]
        end
    end

    assign {restart_s, permit_s, early_s, bdc_s, tdc_s} = sync2_q;
    // Edges by comparing this cycle's sample with the last one
    assign tdc_rise = tdc_s && !prev_q[0]; // [RL20]
    assign tdc_fall = !tdc_s && prev_q[0];
    assign bdc_rise = bdc_s && !prev_q[1];
    assign bdc_fall = !bdc_s && prev_q[1];
    assign early_fall = !early_s && prev_q[2];

    // Drive start comes from logic on this clock, so no synchroniser
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            start_p_q <= 1'b0;
        end else begin
            start_p_q <= drive_start;
        end
    end
    assign start_rise = drive_start && !start_p_q;

    // Control register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (reg_wr && reg_addr == `REG_CTRL_OFS) begin
            ctrl_q <= reg_wdata[`CTRL_WIDTH-1:0];
        end
    end
    assign run_q = ctrl_q[`CTRL_RUN_BIT];
    assign restart_en = ctrl_q[`CTRL_RESTART_EN_BIT];
    assign early_en = ctrl_q[`CTRL_EARLY_EN_BIT];
    assign anyflt_en = ctrl_q[`CTRL_ANYFLT_EN_BIT];
    assign min_cyc = ctrl_q[`CTRL_MIN_LONG_BIT] ? CNT_W'(MIN_LONG_CYC) : CNT_W'(MIN_SHORT_CYC);

    restart_pulse_check #(
        .CNT_W(CNT_W)
    ) u_restart (
        .clock(clock),
        .sys_rst(sys_rst),
        .level(restart_s),
        .min_cyc(min_cyc),
        .max_cyc(CNT_W'(MAX_CYC)),
        .valid(restart_valid)
    );

    // A stopped program clears faults even with the restart input disabled
    assign clear_ev = (restart_en && restart_valid) || !run_q; // [RL10] [RL18]

    // Phase tracking, zone outputs and fault detection
    always_comb begin
        st_d = st_q;
        top_d = top_q;
        up_d = up_q;
        early_dn_d = early_dn_q;
        early_used_d = early_used_q;
        start_seen_d = start_seen_q;
        seq_evt = 1'b0;
        over_evt = 1'b0;
        early_f = early_en && early_fall;
        if (st_q == ST_FAULT) begin
            top_d = 1'b0;
            up_d = 1'b0;
            if (clear_ev) begin
                st_d = ST_HALT;
            end
        end else if (!run_q || !permit_s) begin
            st_d = ST_HALT; // [RL7]
        end else if (st_q == ST_HALT) begin
            // Resume in the phase the contacts show right now
            if (tdc_s) begin
                st_d = bdc_s ? ST_OVER : ST_TOP; // [RL8]
            end else begin
                st_d = bdc_s ? ST_UP : ST_DOWN;
            end
            top_d = tdc_s;
            up_d = bdc_s && !tdc_s;
            early_dn_d = 1'b0;
            early_used_d = 1'b0;
            start_seen_d = 1'b0;
        end else begin
            // Each phase allows one edge; the other switch must stay put
            unique case (st_q)
                ST_TOP: begin
                    if (bdc_rise || bdc_fall) begin
                        seq_evt = 1'b1; // [RL15] [RL19]
                    end else if (tdc_fall) begin
                        st_d = ST_DOWN;
                    end
                end
                ST_DOWN: begin
                    if (tdc_rise || tdc_fall) begin
                        seq_evt = 1'b1; // [RL15] [RL19]
                    end else if (bdc_rise) begin
                        st_d = ST_UP;
                    end
                end
                ST_UP: begin
                    if (bdc_rise || bdc_fall) begin
                        seq_evt = 1'b1; // [RL15] [RL19]
                    end else if (tdc_rise) begin
                        st_d = ST_OVER;
                    end
                end
                ST_OVER: begin
                    if (tdc_rise || tdc_fall) begin
                        seq_evt = 1'b1; // [RL15] [RL19]
                    end else if (bdc_fall) begin
                        st_d = ST_TOP;
                    end
                end
                default: seq_evt = 1'b1;
            endcase
            // Early switch may fall once per press cycle only
            if (early_f && early_used_q) begin
                seq_evt = 1'b1; // [RL15]
            end
            if (tdc_fall) begin
                early_used_d = 1'b0;
                early_dn_d = 1'b0;
            end
            if (early_f) begin
                early_used_d = 1'b1;
            end
            if (early_f && !bdc_s) begin
                early_dn_d = 1'b1; // [RL6]
            end
            // Top zone
            if (tdc_rise || early_f) begin
                top_d = 1'b1; // [RL11]
            end
            if (tdc_fall) begin
                top_d = 1'b0; // [RL12]
            end
            if (early_dn_q && bdc_rise) begin
                top_d = 1'b0; // [RL5]
            end
            // Upstroke zone
            if (bdc_rise && !early_dn_q && !(early_f && !bdc_s)) begin
                up_d = 1'b1; // [RL3] [RL6]
            end
            if (tdc_rise || early_f) begin
                up_d = 1'b0; // [RL4]
            end
            // Drive must have been running while in the top zone
            if (top_q && start_rise) begin
                start_seen_d = 1'b1;
            end
            if (top_q && !top_d) begin
                start_seen_d = 1'b0;
                if (!(start_seen_q || start_rise || drive_start)) begin
                    over_evt = 1'b1; // [RL1] [RL2]
                end
            end
            if (seq_evt || over_evt) begin
                st_d = ST_FAULT;
                top_d = 1'b0; // [RL13]
                up_d = 1'b0;
            end
        end
    end

    // Phase and zone registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_HALT;
            top_q <= 1'b0;
            up_q <= 1'b0;
            early_dn_q <= 1'b0;
            early_used_q <= 1'b0;
            start_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            top_q <= top_d;
            up_q <= up_d;
            early_dn_q <= early_dn_d;
            early_used_q <= early_used_d;
            start_seen_q <= start_seen_d;
        end
    end

    // Fault latches; a new fault in the clearing cycle wins over the clear
    assign seq_fault_d = seq_evt || (seq_fault_q && !clear_ev); // [RL10]
    assign over_fault_d = over_evt || (over_fault_q && !clear_ev);
    assign fault_d = seq_fault_d || over_fault_d;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            seq_fault_q <= 1'b0;
            over_fault_q <= 1'b0;
            pend_q <= 1'b0;
            any_q <= 1'b0;
        end else begin
            seq_fault_q <= seq_fault_d;
            over_fault_q <= over_fault_d;
            pend_q <= fault_d; // [RL14]
            any_q <= anyflt_en && fault_d; // [RL16]
        end
    end

    // Permit follows its input only while nothing is latched
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            permit_q <= 1'b0;
        end else begin
            permit_q <= permit_s && run_q && !fault_d; // [RL7] [RL9] [RL14]
        end
    end

    // Status word and register read port; unmapped reads return zero
    always_comb begin
        status = '0;
        status[`STAT_TOP_BIT] = top_q;
        status[`STAT_UP_BIT] = up_q;
        status[`STAT_PERMIT_BIT] = permit_q;
        status[`STAT_SEQ_BIT] = seq_fault_q;
        status[`STAT_OVER_BIT] = over_fault_q;
        status[`STAT_PEND_BIT] = pend_q;
        status[`STAT_ANY_BIT] = any_q;
        status[`STAT_PHASE_LSB +: 3] = st_q;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `REG_CTRL_OFS: rdata_q <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
                `REG_STATUS_OFS: rdata_q <= status;
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign top_zone = top_q;
    assign upstroke_zone = up_q;
    assign permit_out = permit_q;
    assign seq_fault = seq_fault_q;
    assign overrun_fault = over_fault_q;
    assign reset_pending = pend_q;
    assign any_fault = any_q;

    // Checks on the monitor's own behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic mon;
    assign mon = run_q && permit_s && (st_q != ST_FAULT) && (st_q != ST_HALT);

    sequence s_ramp_miss;
        mon && top_q && tdc_fall && !start_seen_q && !start_rise && !drive_start;
    endsequence
    sequence s_fault_held;
        over_fault_q && !permit_q ##1 reset_pending;
    endsequence
    sequence s_order_break;
        mon && st_q == ST_DOWN && tdc_rise;
    endsequence

    AST_PEND_BLOCKS_PERMIT: assert property (pend_q |-> !permit_q) // [RL14]
        else $error("permit high while reset pending");
    AST_FAULT_ZONES_LOW: assert property ((seq_fault_q || over_fault_q) |-> !top_q && !up_q) // [RL13]
        else $error("zone output high during fault");
    AST_RAMP_FAULT: assert property (s_ramp_miss |=> s_fault_held) // [RL2]
        else $error("missed overrun fault");
    AST_ORDER_FAULT: assert property (s_order_break |=> seq_fault_q && pend_q && !permit_q) // [RL15]
        else $error("missed sequence fault");
    AST_FAULT_LATCH: assert property (seq_fault_q && !clear_ev |=> seq_fault_q) // [RL10]
        else $error("sequence fault dropped without restart");
    AST_ANY_FAULT: assert property ((seq_fault_q || over_fault_q) && anyflt_en && $stable(anyflt_en)
        |-> any_q) // [RL16]
        else $error("any-fault output missing");
    AST_PERMIT_LOW: assert property (!permit_s |=> !permit_q) // [RL7]
        else $error("permit out high with permit input low");
    AST_PERMIT_HIGH: assert property (permit_s && run_q && !fault_d |=> permit_q) // [RL9]
        else $error("permit out low without fault");
    AST_TOP_CLEAR: assert property (mon && tdc_fall |=> !top_q) // [RL12]
        else $error("top zone kept after top-centre fall");
    AST_UP_SET: assert property (mon && st_q == ST_DOWN && bdc_rise && !tdc_rise && !tdc_fall
        && !early_dn_q && !(early_en && early_fall) |=> up_q && st_q == ST_UP) // [RL3]
        else $error("upstroke zone not raised");
    AST_TDC_RISE: assert property (mon && st_q == ST_UP && tdc_rise && !bdc_rise && !bdc_fall
        && !(early_en && early_fall && early_used_q) |=> top_q && !up_q) // [RL11]
        else $error("top-centre rise not handled");
    AST_RESUME: assert property ($rose(permit_s) && run_q && st_q == ST_HALT ##1 !fault_d
        |=> top_q == $past(tdc_s, 1)) // [RL8]
        else $error("resume state does not match contacts");

endmodule // press_contact_sequence_monitor

// [bench/press_drive_model.sv]
// Crank contact switches plus the downstream drive control
module press_drive_model (
    input wire logic clock,
    input wire logic permit_out,
    output logic top_centre_switch,
    output logic startup_zone_switch,
    output logic early_top_switch,
    output logic drive_start
);
    timeunit 1ns;
    timeprecision 1ps;

    logic run_req;

    // Press rests at top centre with the drive requested
    initial begin
        top_centre_switch = 1'b1;
        startup_zone_switch = 1'b0;
        early_top_switch = 1'b1;
        run_req = 1'b1;
    end

    // Drive runs only while released; dropping run_req models a stopped press
    assign drive_start = permit_out & run_req;

    // One contact step, then room for the sync stages and the state update
    task automatic move(input logic tdc, input logic bdc, input logic early);
        @(posedge clock);
        top_centre_switch <= tdc;
        startup_zone_switch <= bdc;
        early_top_switch <= early;
        repeat (6) @(posedge clock);
    endtask

    // Request or withdraw the drive
    task automatic set_run(input logic run);
        @(posedge clock);
        run_req <= run;
        repeat (2) @(posedge clock);
    endtask
endmodule // press_drive_model

// [bench/press_contact_sequence_monitor_tb_top.sv]
// Directed bench; restart limits shrunk so pulses stay short
module press_contact_sequence_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import press_monitor_pkg::*;

    logic clock = 1'b0;
    logic sys_rst;
    logic permit_in;
    logic restart_in;
    logic reg_wr;
    logic reg_rd;
    reg_addr_t reg_addr;
    reg_data_t reg_wdata;
    reg_data_t reg_rdata;
    reg_data_t rd_val;
    logic top_centre_switch, startup_zone_switch, early_top_switch, drive_start;
    logic top_zone, upstroke_zone, permit_out, seq_fault, overrun_fault;
    logic reset_pending, any_fault;
    int failures = 0;
    int total_checks = 0;

    // 25 MHz logic cycle clock
    always #20 clock = ~clock;

    press_drive_model PM (.clock(clock), .permit_out(permit_out),
        .top_centre_switch(top_centre_switch), .startup_zone_switch(startup_zone_switch),
        .early_top_switch(early_top_switch), .drive_start(drive_start));

    press_contact_sequence_monitor #(.MIN_SHORT_CYC(4), .MIN_LONG_CYC(8), .MAX_CYC(40)) DUT (
        .clock(clock), .sys_rst(sys_rst), .top_centre_switch(top_centre_switch),
        .startup_zone_switch(startup_zone_switch), .early_top_switch(early_top_switch),
        .permit_in(permit_in), .restart_in(restart_in), .drive_start(drive_start),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .top_zone(top_zone), .upstroke_zone(upstroke_zone),
        .permit_out(permit_out), .seq_fault(seq_fault), .overrun_fault(overrun_fault),
        .reset_pending(reset_pending), .any_fault(any_fault));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Order: top, upstroke, permit, seq, overrun, pending, any
    task automatic outs(input logic [6:0] exp);
        #1;
        check({25'h0, top_zone, upstroke_zone, permit_out, seq_fault, overrun_fault,
            reset_pending, any_fault}, {25'h0, exp});
    endtask

    task automatic reg_write(input reg_addr_t a, input reg_data_t d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input reg_addr_t a, output reg_data_t d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Low-high-low restart pulse, high for n cycles
    task automatic pulse(input int n);
        @(posedge clock);
        restart_in <= 1'b1;
        repeat (n) @(posedge clock);
        restart_in <= 1'b0;
        repeat (10) @(posedge clock);
    endtask

    // From the down phase back to top centre
    task automatic finish_stroke();
        PM.move(1'b0, 1'b1, 1'b1);
        outs(7'b0110000);
        PM.move(1'b1, 1'b1, 1'b1);
        outs(7'b1010000);
        PM.move(1'b1, 1'b0, 1'b1);
        outs(7'b1010000);
    endtask

    task automatic t_regs();
        reg_read(8'h00, rd_val);
        check(rd_val, 32'h0000_000b);
        reg_read(8'h04, rd_val);
        check(rd_val, 32'h0000_0005);
        reg_write(8'h04, 32'hffff_ffff);
        reg_read(8'h04, rd_val);
        check(rd_val, 32'h0000_0005);
        reg_read(8'h08, rd_val);
        check(rd_val, 32'h0000_0000);
        reg_write(8'h00, 32'hffff_ffeb);
        reg_read(8'h00, rd_val);
        check(rd_val, 32'h0000_000b);
        $display("Done: registers");
    endtask

    task automatic t_normal();
        PM.move(1'b0, 1'b0, 1'b1);
        outs(7'b0010000);
        PM.move(1'b0, 1'b1, 1'b1);
        outs(7'b0110000);
        PM.move(1'b1, 1'b1, 1'b1);
        outs(7'b1010000);
        PM.move(1'b1, 1'b0, 1'b1);
        outs(7'b1010000);
        $display("Done: normal stroke");
    endtask

    // Drive stopped yet top centre is left; bad pulses must not clear
    task automatic t_overrun();
        PM.set_run(1'b0);
        PM.move(1'b0, 1'b0, 1'b1);
        outs(7'b0000111);
        pulse(2);
        outs(7'b0000111);
        pulse(50);
        outs(7'b0000111);
        PM.set_run(1'b1);
        pulse(6);
        outs(7'b0010000);
        finish_stroke();
        $display("Done: overrun");
    endtask

    // Top centre returns before the startup zone: order fault
    task automatic t_seq();
        PM.move(1'b0, 1'b0, 1'b1);
        outs(7'b0010000);
        PM.move(1'b1, 1'b0, 1'b1);
        outs(7'b0001011);
        reg_write(8'h00, 32'h0000_001b);
        pulse(6);
        outs(7'b0001011);
        pulse(10);
        outs(7'b1010000);
        reg_write(8'h00, 32'h0000_000b);
        $display("Done: sequence fault");
    endtask

    // Monitoring suspended while the permit input is low
    task automatic t_permit();
        @(posedge clock);
        permit_in <= 1'b0;
        repeat (6) @(posedge clock);
        outs(7'b1000000);
        PM.move(1'b0, 1'b0, 1'b1);
        PM.move(1'b0, 1'b1, 1'b1);
        outs(7'b1000000);
        @(posedge clock);
        permit_in <= 1'b1;
        repeat (8) @(posedge clock);
        outs(7'b0110000);
        PM.move(1'b1, 1'b1, 1'b1);
        PM.move(1'b1, 1'b0, 1'b1);
        outs(7'b1010000);
        $display("Done: permit");
    endtask

    // Restart disabled: only stopping the logic clears the fault
    task automatic t_restart_off();
        PM.set_run(1'b0);
        PM.move(1'b0, 1'b0, 1'b1);
        outs(7'b0000111);
        reg_write(8'h00, 32'h0000_0009);
        pulse(6);
        outs(7'b0000111);
        reg_write(8'h00, 32'h0000_0001);
        @(posedge clock);
        outs(7'b0000110);
        reg_write(8'h00, 32'h0000_0000);
        repeat (4) @(posedge clock);
        reg_write(8'h00, 32'h0000_000b);
        PM.set_run(1'b1);
        repeat (8) @(posedge clock);
        outs(7'b0010000);
        finish_stroke();
        $display("Done: restart disabled");
    endtask

    // Early-top switch on the upstroke, then during the downward phase
    task automatic t_early();
        PM.move(1'b1, 1'b0, 1'b0);
        outs(7'b1010000);
        reg_write(8'h00, 32'h0000_000f);
        PM.move(1'b0, 1'b0, 1'b0);
        PM.move(1'b0, 1'b0, 1'b1);
        PM.move(1'b0, 1'b1, 1'b1);
        outs(7'b0110000);
        PM.move(1'b0, 1'b1, 1'b0);
        outs(7'b1010000);
        PM.move(1'b1, 1'b1, 1'b0);
        PM.move(1'b1, 1'b0, 1'b0);
        outs(7'b1010000);
        PM.move(1'b0, 1'b0, 1'b0);
        PM.move(1'b0, 1'b0, 1'b1);
        PM.move(1'b0, 1'b0, 1'b0);
        outs(7'b1010000);
        PM.move(1'b0, 1'b1, 1'b0);
        outs(7'b0010000);
        PM.move(1'b1, 1'b1, 1'b0);
        PM.move(1'b1, 1'b0, 1'b0);
        outs(7'b1010000);
        reg_write(8'h00, 32'h0000_000b);
        $display("Done: early top");
    endtask

    // A start rise inside the top zone is enough, even if start is low at its end
    task automatic t_start_pulse();
        PM.set_run(1'b0);
        PM.set_run(1'b1);
        PM.set_run(1'b0);
        PM.move(1'b0, 1'b0, 1'b1);
        outs(7'b0010000);
        PM.set_run(1'b1);
        finish_stroke();
        $display("Done: start pulse");
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        sys_rst <= 1'b1;
        permit_in <= 1'b0;
        restart_in <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= 8'h00;
        reg_wdata <= 32'h0000_0000;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        permit_in <= 1'b1;
        repeat (8) @(posedge clock);
        outs(7'b1010000);
        t_regs();
        t_normal();
        t_overrun();
        t_seq();
        t_permit();
        t_restart_off();
        t_early();
        t_start_pulse();
        wrap_up();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        wrap_up();
    end
endmodule // press_contact_sequence_monitor_tb_top
